// file: rtl/tmr_core.sv
// The implementer's own choices: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "tmr_consts.svh"
module tmr_core #(
    parameter int PRE_W = 8                          // prescaler counter width
) (
    input  wire logic                 clk_in,                  // peripheral clock, 40 MHz
    input  wire logic                 sys_rst_in,              // async reset, active high
    input  wire logic                 hsel_in,                 // ahb select
    input  wire logic [31:0]          haddr_in,                // ahb address
    input  wire logic [1:0]           htrans_in,               // ahb transfer type
    input  wire logic                 hwrite_in,               // ahb write
    input  wire logic [2:0]           hsize_in,                // ahb size, word only
    input  wire logic [31:0]          hwdata_in,               // ahb write data
    input  wire logic                 hready_in,               // ahb ready
    output logic      [31:0]          hrdata_out,              // ahb read data
    output logic                      hreadyout_out,           // ahb ready out
    output logic                      hresp_out,               // ahb response
    input  wire logic                 trigger_input_first_in,  // first trigger input
    input  wire logic                 trigger_input_second_in, // second trigger input
    output logic                      timer_output_pin_out,    // timer output
    output logic                      first_match_irq_out,     // first match/capture pulse
    output logic                      second_match_irq_out,    // second match/capture pulse
    output tmr_pkg::tmr_mode_t        mode_out                 // current operating mode
);
    import tmr_pkg::*;

    function automatic logic edge_hit(input logic r, input logic f, input logic [1:0] sel);
        edge_hit = (r && (sel == `TMR_ES_RISE || sel == `TMR_ES_BOTH))
                || (f && (sel == `TMR_ES_FALL || sel == `TMR_ES_BOTH));
    endfunction : edge_hit

    tmr_mode_t     mode_reg,   mode_next;
    tmr_os_state_t os_reg,     os_next;
    logic          ovf_reg,    ovf_next;
    logic          hold_reg,   hold_next;
    logic [7:0]    prs_reg,    prs_next;
    logic [2:0]    crc_reg,    crc_next;
    logic [`TMR_TOC_MSB:0] toc_reg, toc_next;
    logic [15:0]   cnt_reg,    cnt_next;
    logic [15:0]   cc1_reg,    cc1_next;
    logic [15:0]   cc2_reg,    cc2_next;
    logic [PRE_W-1:0] pre_reg, pre_next;
    logic          pend1_reg,  pend1_next;
    logic          pend2_reg,  pend2_next;
    logic          irq1_next,  irq2_next;
    logic          out_reg,    out_next;
    logic          dsel_reg,   dwrite_reg;
    logic [7:0]    daddr_reg;
    logic [31:0]   rdata_next;

    logic       running, ext_clk, pre_tick, tick, sample_en, wr_en, addr_ok, os_allowed;
    logic       f_rise, f_fall, s_rise, s_fall, f_valid, f_rev, s_valid, m1, m2;
    logic [1:0] prs_sel, es1, es2;

    assign running   = (mode_reg != TMR_MODE_STOP);
    assign prs_sel   = prs_reg[`TMR_PRS_MSB:`TMR_PRS_LSB];
    assign es1       = prs_reg[`TMR_ES1_MSB:`TMR_ES1_LSB];
    assign es2       = prs_reg[`TMR_ES2_MSB:`TMR_ES2_LSB];
    assign ext_clk   = (prs_sel == `TMR_SEL_EXT);
    // prescaler runs free, so a start lands anywhere in the count period
    assign pre_tick  = (prs_sel == `TMR_SEL_FULL)
                    || (prs_sel == `TMR_SEL_DIV4
                        && (pre_reg[7:0] & `TMR_DIV4_MASK) == `TMR_DIV4_MASK)
                    || (prs_sel == `TMR_SEL_DIV16
                        && (pre_reg[7:0] & `TMR_DIV16_MASK) == `TMR_DIV16_MASK);
    assign sample_en = ext_clk ? 1'b1 : pre_tick;
    assign f_valid   = edge_hit(f_rise, f_fall, es1);
    assign f_rev     = (es1 != `TMR_ES_BOTH) && edge_hit(f_fall, f_rise, es1);
    assign s_valid   = edge_hit(s_rise, s_fall, es2);
    assign tick      = running && (ext_clk ? f_valid : pre_tick);
    assign m1        = tick && cnt_reg == cc1_reg;
    assign m2        = tick && cnt_reg == cc2_reg;
    assign wr_en     = dsel_reg && dwrite_reg;
    assign addr_ok   = hsel_in && hready_in && htrans_in[1];
    assign os_allowed = toc_reg[`TMR_TOC_OSE]
                     && (mode_reg == TMR_MODE_FREE || mode_reg == TMR_MODE_CLR_EDGE);

    assign hreadyout_out        = 1'b1;
    assign hresp_out            = 1'b0;
    assign timer_output_pin_out = out_reg;
    assign mode_out             = mode_reg;

    tmr_edge_filter u_filt_first (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .pin_in     (trigger_input_first_in),
        .sample_in  (sample_en),
        .run_in     (running),
        .rise_out   (f_rise),
        .fall_out   (f_fall)
    );

    tmr_edge_filter u_filt_second (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .pin_in     (trigger_input_second_in),
        .sample_in  (sample_en),
        .run_in     (running),
        .rise_out   (s_rise),
        .fall_out   (s_fall)
    );

    always_comb begin
        mode_next  = mode_reg;
        os_next    = os_reg;
        ovf_next   = ovf_reg;
        hold_next  = hold_reg;
        prs_next   = prs_reg;
        crc_next   = crc_reg;
        toc_next   = toc_reg;
        cnt_next   = cnt_reg;
        cc1_next   = cc1_reg;
        cc2_next   = cc2_reg;
        pre_next   = pre_reg + {{(PRE_W-1){1'b0}}, 1'b1};
        pend1_next = pend1_reg;
        pend2_next = pend2_reg;
        irq1_next  = 1'b0;
        irq2_next  = 1'b0;
        out_next   = out_reg;
        rdata_next = 32'h0000_0000;

        case (haddr_in[7:0])
            `TMR_OFF_MODE: begin
                rdata_next[`TMR_MODE_MSB:`TMR_MODE_LSB] = mode_reg;
                rdata_next[`TMR_OVF_BIT] = ovf_reg;
            end
            `TMR_OFF_PRS:   rdata_next[7:0]  = prs_reg;
            `TMR_OFF_CRC:   rdata_next[2:0]  = crc_reg;
            `TMR_OFF_TOC:   rdata_next[`TMR_TOC_MSB:0] = toc_reg;
            `TMR_OFF_COUNT: rdata_next[15:0] = cnt_reg;
            `TMR_OFF_CC1:   rdata_next[15:0] = cc1_reg;
            `TMR_OFF_CC2:   rdata_next[15:0] = cc2_reg;
            default:        rdata_next = 32'h0000_0000;
        endcase

        if (wr_en) begin
            case (daddr_reg)
                `TMR_OFF_MODE: begin
                    mode_next = tmr_mode_t'(hwdata_in[`TMR_MODE_MSB:`TMR_MODE_LSB]);
                    if (!hwdata_in[`TMR_OVF_BIT] && !hold_reg) begin
                        ovf_next = 1'b0;
                    end
                end
                `TMR_OFF_PRS:  prs_next = hwdata_in[7:0];
                `TMR_OFF_CRC:  crc_next = hwdata_in[2:0];
                `TMR_OFF_TOC:  toc_next = hwdata_in[`TMR_TOC_MSB:0];
                `TMR_OFF_CC1:  cc1_next = hwdata_in[15:0];
                `TMR_OFF_CC2:  cc2_next = hwdata_in[15:0];
                default:       mode_next = mode_reg;
            endcase
        end

        // stop zeroes the count; capture/compare registers are left as they are
        if (!running) begin
            cnt_next  = `TMR_CNT_ZERO;
            hold_next = 1'b0;
            if (toc_reg[`TMR_TOC_LVS] && !toc_reg[`TMR_TOC_LVR]) begin
                out_next = 1'b1;
            end else if (toc_reg[`TMR_TOC_LVR] && !toc_reg[`TMR_TOC_LVS]) begin
                out_next = 1'b0;
            end
        end else if (tick) begin
            if (cnt_reg == `TMR_CNT_ZERO) begin
                hold_next = 1'b0;
            end
            if (mode_reg == TMR_MODE_CLR_MATCH && cnt_reg == cc1_reg) begin
                cnt_next = `TMR_CNT_ZERO;
            end else begin
                cnt_next = cnt_reg + `TMR_CNT_ONE;
            end
            if (cnt_reg == `TMR_CNT_MAX) begin
                ovf_next  = 1'b1;
                hold_next = 1'b1;
            end
        end

        if (running && mode_reg == TMR_MODE_CLR_EDGE && f_valid) begin
            cnt_next = `TMR_CNT_ZERO;
        end

        // count-clock interrupt: pending captures and compare matches fire here
        if (tick) begin
            irq1_next  = pend1_reg || (!crc_reg[`TMR_CRC_CAP1] && m1);
            irq2_next  = pend2_reg || (!crc_reg[`TMR_CRC_CAP2] && m2);
            pend1_next = 1'b0;
            pend2_next = 1'b0;
        end

        // captures proceed regardless of any read in progress
        if (crc_reg[`TMR_CRC_CAP2] && f_valid) begin
            cc2_next   = cnt_reg;
            pend2_next = 1'b1;
        end
        if (crc_reg[`TMR_CRC_CAP1]) begin
            if (!crc_reg[`TMR_CRC_REV] && s_valid) begin
                cc1_next   = cnt_reg;
                pend1_next = 1'b1;
            end else if (crc_reg[`TMR_CRC_REV]) begin
                if (f_rev) begin
                    cc1_next = cnt_reg;
                end
                if (s_valid) begin
                    pend1_next = 1'b1;
                end
            end
        end

        case (os_reg)
            TMR_OS_IDLE: begin
                if (os_allowed && (f_valid || (wr_en && daddr_reg == `TMR_OFF_TOC
                                               && hwdata_in[`TMR_TOC_OST]))) begin
                    os_next = TMR_OS_ARMED;
                end
            end
            TMR_OS_ARMED: begin
                if (m2) begin
                    os_next  = TMR_OS_ACTIVE;
                    out_next = 1'b1;
                end
            end
            TMR_OS_ACTIVE: begin
                // a trigger here is not expected and is simply not acted on
                if (m1) begin
                    os_next  = TMR_OS_IDLE;
                    out_next = 1'b0;
                end
            end
            default: os_next = TMR_OS_IDLE;
        endcase
        if (!os_allowed) begin
            os_next = TMR_OS_IDLE;
        end

        if (running && toc_reg[`TMR_TOC_OE] && !toc_reg[`TMR_TOC_OSE]) begin
            if (m1 != (m2 && toc_reg[`TMR_TOC_INV2])) begin
                out_next = ~out_reg;
            end
        end
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            mode_reg             <= TMR_MODE_STOP;
            os_reg               <= TMR_OS_IDLE;
            ovf_reg              <= 1'b0;
            hold_reg             <= 1'b0;
            prs_reg              <= `TMR_PRS_RST;
            crc_reg              <= `TMR_CRC_RST;
            toc_reg              <= `TMR_TOC_RST;
            cnt_reg              <= `TMR_CNT_ZERO;
            cc1_reg              <= `TMR_CNT_ZERO;
            cc2_reg              <= `TMR_CNT_ZERO;
            pre_reg              <= '0;
            pend1_reg            <= 1'b0;
            pend2_reg            <= 1'b0;
            first_match_irq_out  <= 1'b0;
            second_match_irq_out <= 1'b0;
            out_reg              <= 1'b0;
            dsel_reg             <= 1'b0;
            dwrite_reg           <= 1'b0;
            daddr_reg            <= 8'h00;
            hrdata_out           <= 32'h0000_0000;
        end else begin
            mode_reg             <= mode_next;
            os_reg               <= os_next;
            ovf_reg              <= ovf_next;
            hold_reg             <= hold_next;
            prs_reg              <= prs_next;
            crc_reg              <= crc_next;
            toc_reg              <= toc_next;
            cnt_reg              <= cnt_next;
            cc1_reg              <= cc1_next;
            cc2_reg              <= cc2_next;
            pre_reg              <= pre_next;
            pend1_reg            <= pend1_next;
            pend2_reg            <= pend2_next;
            first_match_irq_out  <= irq1_next;
            second_match_irq_out <= irq2_next;
            out_reg              <= out_next;
            dsel_reg             <= addr_ok;
            dwrite_reg           <= addr_ok && hwrite_in;
            daddr_reg            <= haddr_in[7:0];
            hrdata_out           <= rdata_next;
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);

    AST_STOP_HOLDS_ZERO: assert property (
        (mode_reg == TMR_MODE_STOP) ##1 (mode_reg == TMR_MODE_STOP) |-> cnt_reg == `TMR_CNT_ZERO)
        else $error("counter not held at zero while stopped");

    AST_FREE_INCREMENT: assert property (
        (tick && mode_reg == TMR_MODE_FREE && !wr_en)
        |=> cnt_reg == $past(cnt_reg) + `TMR_CNT_ONE)
        else $error("free-running count did not advance by one");

    AST_EDGE_CLEAR: assert property (
        (f_valid && mode_reg == TMR_MODE_CLR_EDGE && !wr_en) |=> cnt_reg == `TMR_CNT_ZERO)
        else $error("valid first edge did not clear counter");

    AST_MATCH_CLEAR: assert property (
        (tick && mode_reg == TMR_MODE_CLR_MATCH && cnt_reg == cc1_reg && !wr_en)
        |=> cnt_reg == `TMR_CNT_ZERO)
        else $error("first compare match did not clear counter");

    AST_OVF_ON_WRAP: assert property (
        (tick && cnt_reg == `TMR_CNT_MAX) |=> ovf_reg && hold_reg)
        else $error("overflow flag missed at FFFF");

    AST_OVF_CLEAR_BLOCKED: assert property (
        (ovf_reg && hold_reg) |=> ovf_reg)
        else $error("overflow cleared before count reached 0001");

    AST_CAPTURE_IRQ_NEXT_TICK: assert property (
        (pend2_reg && tick) |=> second_match_irq_out ##1 !second_match_irq_out)
        else $error("capture interrupt not one pulse at next count clock");

    AST_REVERSE_NO_IRQ: assert property (
        (crc_reg[`TMR_CRC_CAP1] && crc_reg[`TMR_CRC_REV] && f_rev && !s_valid
         && !pend1_reg && !wr_en)
        |=> !pend1_reg && cc1_reg == $past(cnt_reg))
        else $error("reverse-phase capture wrong or raised interrupt");

    AST_SECOND_EDGE_IRQ_ONLY: assert property (
        (crc_reg[`TMR_CRC_CAP1] && crc_reg[`TMR_CRC_REV] && s_valid && !f_rev && !wr_en)
        |=> pend1_reg && $stable(cc1_reg))
        else $error("second edge under reverse capture mishandled");

    AST_NO_ONESHOT_MATCH_MODE: assert property (
        $past(mode_reg) == TMR_MODE_CLR_MATCH && mode_reg == TMR_MODE_CLR_MATCH
        |-> os_reg == TMR_OS_IDLE)
        else $error("one-shot active in clear-on-match mode");
endmodule : tmr_core

// file: rtl/tmr_consts.svh
// Operation
// - Counting starts unaligned to the count pulse; first match may slip one clock.
// - Capture still happens during a read; interrupt only for valid edges.
// - Capture/compare contents are not guaranteed after the channel stops.
// - Overflow flag sets on wrap and on FFFF match-clear.
// - Clearing overflow before the count reaches 0001 is ignored.
// - One-shot only in free-running and clear-on-edge modes.
// - Capture on the count clock, interrupt at the next count clock.
// - Reverse-phase capture raises no interrupt; second-input edge only interrupts.
// - First enable after reset sees a high input as a rising edge.
// - First-input filter samples at peripheral clock or at count clock.
// - An edge needs the new level on two consecutive samples.
// - Trigger inputs are ignored while the channel is stopped.
// - Mode 01 runs free, mode 00 holds the counter stopped.
// - Mode 10 clears and starts on the first input's valid edge; here the counter runs from the mode write and the edge only clears it.
`ifndef TMR_CONSTS_SVH
`define TMR_CONSTS_SVH

`define TMR_OFF_MODE      8'h00
`define TMR_OFF_PRS       8'h04
`define TMR_OFF_CRC       8'h08
`define TMR_OFF_TOC       8'h0C
`define TMR_OFF_COUNT     8'h10
`define TMR_OFF_CC1       8'h14
`define TMR_OFF_CC2       8'h18

`define TMR_OVF_BIT       0
`define TMR_MODE_LSB      2
`define TMR_MODE_MSB      3
`define TMR_PRS_LSB       0
`define TMR_PRS_MSB       1
`define TMR_ES1_LSB       4
`define TMR_ES1_MSB       5
`define TMR_ES2_LSB       6
`define TMR_ES2_MSB       7
`define TMR_CRC_CAP1      0
`define TMR_CRC_REV       1
`define TMR_CRC_CAP2      2
`define TMR_TOC_OE        0
`define TMR_TOC_LVR       2
`define TMR_TOC_LVS       3
`define TMR_TOC_INV2      4
`define TMR_TOC_OSE       5
`define TMR_TOC_OST       6
`define TMR_TOC_MSB       5

`define TMR_CNT_ZERO      16'h0000
`define TMR_CNT_ONE       16'h0001
`define TMR_CNT_MAX       16'hFFFF
`define TMR_PRS_RST       8'h00
`define TMR_CRC_RST       3'h0
`define TMR_TOC_RST       6'h00
`define TMR_DIV4_MASK     8'h03
`define TMR_DIV16_MASK    8'h0F

`define TMR_SEL_FULL      2'h0
`define TMR_SEL_DIV4      2'h1
`define TMR_SEL_DIV16     2'h2
`define TMR_SEL_EXT       2'h3
`define TMR_ES_FALL       2'h0
`define TMR_ES_RISE       2'h1
`define TMR_ES_BOTH       2'h3

`endif

// file: rtl/tmr_pkg.sv
package tmr_pkg;
    typedef enum logic [1:0] {
        TMR_MODE_STOP      = 2'h0,
        TMR_MODE_FREE      = 2'h1,
        TMR_MODE_CLR_EDGE  = 2'h2,
        TMR_MODE_CLR_MATCH = 2'h3
    } tmr_mode_t;

    typedef enum logic [1:0] {
        TMR_OS_IDLE   = 2'h0,
        TMR_OS_ARMED  = 2'h1,
        TMR_OS_ACTIVE = 2'h3
    } tmr_os_state_t;
endpackage : tmr_pkg

// file: rtl/tmr_edge_filter.sv
`timescale 1ns/1ps
module tmr_edge_filter (
    input  wire logic clk_in,      // peripheral clock
    input  wire logic sys_rst_in,  // async reset, active high
    input  wire logic pin_in,      // trigger input level
    input  wire logic sample_in,   // sampling strobe
    input  wire logic run_in,      // channel running
    output logic      rise_out,    // filtered rising edge pulse
    output logic      fall_out     // filtered falling edge pulse
);
    logic samp_reg,  samp_next;
    logic level_reg, level_next;
    logic seen_reg,  seen_next;
    logic rise_next, fall_next;

    always_comb begin
        samp_next  = sample_in ? pin_in : samp_reg;
        level_next = level_reg;
        rise_next  = 1'b0;
        fall_next  = 1'b0;
        seen_next  = seen_reg | run_in;
        if (!run_in) begin
            level_next = seen_reg ? pin_in : 1'b0;
        end else if (sample_in && pin_in == samp_reg && pin_in != level_reg) begin
            level_next = pin_in;
            rise_next  = pin_in;
            fall_next  = ~pin_in;
        end
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            samp_reg  <= 1'b0;
            level_reg <= 1'b0;
            seen_reg  <= 1'b0;
            rise_out  <= 1'b0;
            fall_out  <= 1'b0;
        end else begin
            samp_reg  <= samp_next;
            level_reg <= level_next;
            seen_reg  <= seen_next;
            rise_out  <= rise_next;
            fall_out  <= fall_next;
        end
    end

    AST_FILT_STOPPED_SILENT: assert property (
        @(posedge clk_in) disable iff (sys_rst_in)
        (rise_out || fall_out) |-> $past(run_in))
        else $error("edge reported while channel stopped");
endmodule : tmr_edge_filter

// file: tb/tmr_pulse_src.sv
`timescale 1ns/1ps
module tmr_pulse_src (
    input  wire logic       clk_in,   // peripheral clock
    input  wire logic       fire_in,  // start one pulse
    input  wire logic [3:0] width_in, // pulse high cycles
    output logic            pin_out   // trigger line
);
    logic [3:0] left_reg;
    initial begin
        left_reg = 4'h0;
    end
    always @(posedge clk_in) begin
        if (fire_in && left_reg == 4'h0) begin
            left_reg <= (width_in < 4'h3) ? 4'h3 : width_in;
        end else if (left_reg != 4'h0) begin
            left_reg <= left_reg - 4'h1;
        end
    end
    assign pin_out = (left_reg != 4'h0);
endmodule : tmr_pulse_src

// file: tb/timer16_capture_compare_rules_bench.sv
`timescale 1ns/1ps
`include "tmr_consts.svh"
module timer16_capture_compare_rules_bench;
    import tmr_pkg::*;
    logic        clk_in, sys_rst_in, hsel, hwrite, hready, hresp;
    logic        f1, f2, t1, t2, irq1, irq2, pin;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [3:0]  w1, w2;
    tmr_mode_t   mode;
    int          err_total, samples_checked, cyc, n1, n2, nhi, base, nval, g;
    logic [7:0]  offs [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h40};

    tmr_core u_dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .hsel_in(hsel),
        .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
        .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata),
        .hreadyout_out(hready), .hresp_out(hresp), .trigger_input_first_in(t1),
        .trigger_input_second_in(t2), .timer_output_pin_out(pin),
        .first_match_irq_out(irq1), .second_match_irq_out(irq2), .mode_out(mode));
    tmr_pulse_src u_src1 (.clk_in(clk_in), .fire_in(f1), .width_in(w1), .pin_out(t1));
    tmr_pulse_src u_src2 (.clk_in(clk_in), .fire_in(f2), .width_in(w2), .pin_out(t2));

    always #12.5 clk_in = ~clk_in;

    always @(posedge clk_in) begin
        cyc++;
        if (irq1 === 1'b1) n1++;
        if (irq2 === 1'b1) n2++;
        if (pin === 1'b1) nhi++;
        if (cyc == 90000) begin
            err_total++;
            finish_test();
        end
    end

    task finish_test();
        $display("errors %0d, checks %0d", err_total, samples_checked);
        if (err_total == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : finish_test

    task check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task ahb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge clk_in);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {24'h0, a};
        hwrite <= w;
        do @(posedge clk_in); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk_in); while (hready !== 1'b1);
        rd = hrdata;
    endtask : ahb

    task fire(input logic a, input logic b, input logic [3:0] w);
        @(posedge clk_in);
        f1 <= a;
        f2 <= b;
        w1 <= w;
        w2 <= w;
        @(posedge clk_in);
        f1 <= 1'b0;
        f2 <= 1'b0;
    endtask : fire

    // cycles until the next first-match pulse
    task gap(output int n);
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while (irq1 !== 1'b1);
    endtask : gap

    // clocks between first-match pulses in clear-on-match mode
    function automatic int period(input int n, input int sel);
        return (n + 1) << (2 * sel);
    endfunction : period

    initial begin
        clk_in = 1'b0;
        sys_rst_in = 1'b1;
        hsel = 1'b0;
        htrans = 2'h0;
        haddr = 32'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        f1 = 1'b0;
        f2 = 1'b0;
        w1 = 4'h0;
        w2 = 4'h0;
        err_total = 0;
        samples_checked = 0;
        cyc = 0;
        n1 = 0;
        n2 = 0;
        nhi = 0;
        void'($urandom(13796));
        repeat (2) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        foreach (offs[i]) begin
            ahb(offs[i], 1'b0, 32'h0);
            check(rd, 32'h0);
            check({31'h0, hresp}, 32'h0);
        end
        // triggers while stopped
        ahb(`TMR_OFF_PRS, 1'b1, 32'h50);
        ahb(`TMR_OFF_CRC, 1'b1, 32'h5);
        fire(1'b1, 1'b1, 4'h5);
        repeat (20) @(posedge clk_in);
        ahb(`TMR_OFF_CC1, 1'b0, 32'h0);
        check(rd, 32'h0);
        ahb(`TMR_OFF_CC2, 1'b0, 32'h0);
        check(rd, 32'h0);
        check(n1 + n2, 0);
        // clear-on-match period at each prescaler step, smallest legal compare first
        ahb(`TMR_OFF_CRC, 1'b1, 32'h0);
        for (int k = 0; k < 4; k++) begin
            nval = (k == 0) ? 1 : $urandom_range(40, 2);
            ahb(`TMR_OFF_PRS, 1'b1, k % 3);
            ahb(`TMR_OFF_CC1, 1'b1, nval);
            ahb(`TMR_OFF_CC2, 1'b1, nval);
            ahb(`TMR_OFF_MODE, 1'b1, 32'hC);
            gap(g);
            gap(g);
            check(g, period(nval, k % 3));
            check({30'h0, mode}, 32'h3);
            ahb(`TMR_OFF_MODE, 1'b1, 32'h0);
        end
        // match-clear at full scale sets the overflow flag
        ahb(`TMR_OFF_CC1, 1'b1, 32'hFFFF);
        ahb(`TMR_OFF_CC2, 1'b1, 32'hFFFF);
        ahb(`TMR_OFF_MODE, 1'b1, 32'hC);
        gap(g);
        ahb(`TMR_OFF_MODE, 1'b0, 32'h0);
        check(rd, 32'hD);
        ahb(`TMR_OFF_MODE, 1'b1, 32'hC);
        ahb(`TMR_OFF_MODE, 1'b0, 32'h0);
        check(rd, 32'hC);
        ahb(`TMR_OFF_MODE, 1'b1, 32'h0);
        // capture into the second register on a first-input rise
        ahb(`TMR_OFF_PRS, 1'b1, 32'h10);
        ahb(`TMR_OFF_CRC, 1'b1, 32'h4);
        ahb(`TMR_OFF_MODE, 1'b1, 32'h4);
        base = n2;
        fire(1'b1, 1'b0, 4'($urandom_range(8, 3)));
        repeat (30) @(posedge clk_in);
        check(n2 - base, 1);
        ahb(`TMR_OFF_CC2, 1'b0, 32'h0);
        check({31'h0, rd != 32'h0 && rd < 32'h40}, 32'h1);
        // clear on the first input's edge; the counter runs from the mode write
        ahb(`TMR_OFF_MODE, 1'b1, 32'h0);
        ahb(`TMR_OFF_TOC, 1'b1, 32'h0);
        ahb(`TMR_OFF_MODE, 1'b1, 32'h8);
        repeat (200) @(posedge clk_in);
        fire(1'b1, 1'b0, 4'h4);
        repeat (6) @(posedge clk_in);
        ahb(`TMR_OFF_COUNT, 1'b0, 32'h0);
        check({31'h0, rd < 32'h40}, 32'h1);
        // reverse-phase capture into the first register, second input only interrupts
        ahb(`TMR_OFF_MODE, 1'b1, 32'h0);
        ahb(`TMR_OFF_TOC, 1'b1, 32'h0);
        ahb(`TMR_OFF_CRC, 1'b1, 32'h3);
        ahb(`TMR_OFF_MODE, 1'b1, 32'h4);
        base = n1;
        fire(1'b1, 1'b0, 4'($urandom_range(8, 3)));
        repeat (30) @(posedge clk_in);
        check(n1 - base, 0);
        ahb(`TMR_OFF_CC1, 1'b0, 32'h0);
        check({31'h0, rd != 32'h0 && rd < 32'h40}, 32'h1);
        fire(1'b0, 1'b1, 4'h4);
        repeat (30) @(posedge clk_in);
        check(n1 - base, 1);
        // one-shot: high from second compare match to first compare match
        ahb(`TMR_OFF_MODE, 1'b1, 32'h0);
        ahb(`TMR_OFF_CRC, 1'b1, 32'h0);
        ahb(`TMR_OFF_CC1, 1'b1, 32'h50);
        ahb(`TMR_OFF_CC2, 1'b1, 32'h40);
        ahb(`TMR_OFF_MODE, 1'b1, 32'h4);
        ahb(`TMR_OFF_TOC, 1'b1, 32'h20);
        base = nhi;
        ahb(`TMR_OFF_TOC, 1'b1, 32'h60);
        repeat (120) @(posedge clk_in);
        check(nhi - base, 32'h10);
        // no one-shot in clear-on-match mode
        ahb(`TMR_OFF_MODE, 1'b1, 32'h0);
        ahb(`TMR_OFF_MODE, 1'b1, 32'hC);
        base = nhi;
        ahb(`TMR_OFF_TOC, 1'b1, 32'h60);
        repeat (120) @(posedge clk_in);
        check(nhi - base, 0);
        // external event counting on the first input
        ahb(`TMR_OFF_MODE, 1'b1, 32'h0);
        ahb(`TMR_OFF_TOC, 1'b1, 32'h0);
        ahb(`TMR_OFF_CRC, 1'b1, 32'h0);
        ahb(`TMR_OFF_PRS, 1'b1, 32'h13);
        ahb(`TMR_OFF_MODE, 1'b1, 32'h4);
        nval = $urandom_range(8, 1);
        for (int k = 0; k < nval; k++) begin
            fire(1'b1, 1'b0, 4'h3);
            repeat (6) @(posedge clk_in);
        end
        ahb(`TMR_OFF_COUNT, 1'b0, 32'h0);
        check(rd, nval);
        ahb(`TMR_OFF_MODE, 1'b1, 32'h0);
        finish_test();
    end
endmodule : timer16_capture_compare_rules_bench
